// file: logic/ibq_regs.vh
`ifndef IBQ_REGS_VH
`define IBQ_REGS_VH

`define IBQ_AW           17
`define IBQ_DW           32
`define IBQ_IDX_W        15
`define IBQ_SEL_W        3
`define IBQ_ADDR_SW_W    12
`define IBQ_VEC_SW_W     8
`define IBQ_VEC_W        9
`define IBQ_CAUSE_W      6

`define IBQ_IO_PAGE_TOP  3'h7
`define IBQ_ADDR_SW_DEF  12'h034
`define IBQ_VEC_SW_DEF   8'h11

`define IBQ_SEL_CSR      3'h0
`define IBQ_SEL_DATA     3'h1
`define IBQ_SEL_STATUS   3'h2
`define IBQ_SEL_ENABLE   3'h3
`define IBQ_SEL_CLEAR    3'h4
`define IBQ_SEL_VECTOR   3'h5
`define IBQ_SEL_LAST     3'h5

`define IBQ_CSR_HOLD_TX  0
`define IBQ_CSR_TALKER   1
`define IBQ_CSR_LISTENER 2
`define IBQ_CSR_RX_FULL  3
`define IBQ_CSR_SOLE     4
`define IBQ_CSR_IRQ      5

`define IBQ_C_ERR1       0
`define IBQ_C_ERR2       1
`define IBQ_C_SRQ        2
`define IBQ_C_CMD        3
`define IBQ_C_TKR        4
`define IBQ_C_LNR        5

`define IBQ_SLOT_ERR     2'h0
`define IBQ_SLOT_SRQ     2'h1
`define IBQ_SLOT_TALK    2'h2
`define IBQ_SLOT_LISTEN  2'h3

`define IBQ_SW_BASE_HI   4
`define IBQ_SW_BASE_LO   0
`define IBQ_SW_SOLE      7

`endif

// file: logic/ibq_addr_decode.v
`include "ibq_regs.vh"
`default_nettype none

module ibq_addr_decode
(
   input  wire [`IBQ_AW-1:0]        paddr,
   input  wire [`IBQ_ADDR_SW_W-1:0] address_switch_bank,
   output reg                       hit,
   output reg  [`IBQ_SEL_W-1:0]     sel
);

   function [`IBQ_IDX_W-1:0] word_index;
      input [`IBQ_AW-1:0] a;
      begin
         word_index = a[`IBQ_AW-1:2];
      end
   endfunction

   wire [`IBQ_IDX_W-1:0] csr_index;
   reg  [`IBQ_IDX_W-1:0] rel;

   // only the csr index comes from switches; everything else is relative to it
   assign csr_index = {`IBQ_IO_PAGE_TOP, address_switch_bank};

   always @*
   begin
      rel = word_index(paddr) - csr_index;
      hit = (rel <= {{(`IBQ_IDX_W-`IBQ_SEL_W){1'b0}}, `IBQ_SEL_LAST});
      sel = rel[`IBQ_SEL_W-1:0];
   end

endmodule
`default_nettype wire

// file: logic/ibq_prio.v
`include "ibq_regs.vh"
`default_nettype none

module ibq_prio
(
   input  wire [`IBQ_CAUSE_W-1:0] pend,
   input  wire [4:0]              base,
   output reg                     any,
   output reg  [1:0]              slot,
   output reg  [`IBQ_CAUSE_W-1:0] served,
   output wire [`IBQ_VEC_W-1:0]   vector
);

   // two causes share each of the error and talker slots
   always @*
   begin
      any    = |pend;
      slot   = `IBQ_SLOT_ERR;
      served = {`IBQ_CAUSE_W{1'b0}};
      if (pend[`IBQ_C_ERR1] | pend[`IBQ_C_ERR2])
      begin
         slot = `IBQ_SLOT_ERR;
         served[`IBQ_C_ERR1] = 1'b1;
         served[`IBQ_C_ERR2] = 1'b1;
      end
      else if (pend[`IBQ_C_SRQ])
      begin
         slot = `IBQ_SLOT_SRQ;
         served[`IBQ_C_SRQ] = 1'b1;
      end
      else if (pend[`IBQ_C_CMD] | pend[`IBQ_C_TKR])
      begin
         slot = `IBQ_SLOT_TALK;
         served[`IBQ_C_CMD] = 1'b1;
         served[`IBQ_C_TKR] = 1'b1;
      end
      else if (pend[`IBQ_C_LNR])
      begin
         slot = `IBQ_SLOT_LISTEN;
         served[`IBQ_C_LNR] = 1'b1;
      end
   end

   // bits 1:0 of a vector are always zero
   assign vector = {base, slot, 2'b00};

endmodule
`default_nettype wire

// file: logic/ibq_irq_vectoring.v
`include "ibq_regs.vh"
`default_nettype none

module ibq_irq_vectoring
(
   input  wire                      pclk,
   input  wire                      presetn,
   input  wire                      psel,
   input  wire                      penable,
   input  wire                      pwrite,
   input  wire [`IBQ_AW-1:0]        paddr,
   input  wire [`IBQ_DW-1:0]        pwdata,
   output reg  [`IBQ_DW-1:0]        prdata,
   output wire                      pready,
   output wire                      pslverr,
   input  wire [`IBQ_ADDR_SW_W-1:0] address_switch_bank,
   input  wire [`IBQ_VEC_SW_W-1:0]  vector_switch_bank,
   input  wire                      error_source_one,
   input  wire                      error_source_two,
   input  wire                      service_request,
   input  wire                      command_event,
   input  wire                      talker_active,
   input  wire                      listener_active,
   input  wire                      tx_ready,
   input  wire                      rx_valid,
   input  wire [7:0]                rx_byte,
   output reg                       tx_valid,
   output reg  [7:0]                tx_byte,
   output wire                      ppoll_drive,
   input  wire                      iack,
   output reg                       vector_valid,
   output reg  [`IBQ_VEC_W-1:0]     vector_out,
   output wire                      irq
);

   wire                     hit;
   wire [`IBQ_SEL_W-1:0]    sel;
   wire                     any_pend;
   wire [1:0]               slot;
   wire [`IBQ_CAUSE_W-1:0]  served;
   wire [`IBQ_VEC_W-1:0]    next_vector;
   wire [`IBQ_CAUSE_W-1:0]  pend;
   wire [`IBQ_CAUSE_W-1:0]  events;
   wire [4:0]               base;
   wire                     sole_controller;
   wire                     setup;
   wire                     access_wr;
   wire                     access_rd;
   wire                     talk_ready;

   reg                      err_q;
   reg  [`IBQ_SEL_W-1:0]    sel_q;
   reg                      hold_tx;
   reg                      rx_full;
   reg  [7:0]               rx_hold;
   reg  [`IBQ_CAUSE_W-1:0]  status;
   reg  [`IBQ_CAUSE_W-1:0]  enable;
   reg  [`IBQ_CAUSE_W-1:0]  next_status;
   reg  [`IBQ_DW-1:0]       next_prdata;
   reg                      talk_ready_q;
   reg                      srq_q;
   reg  [`IBQ_VEC_W-1:0]    last_vector;

   // word index decode; unmapped words answer with an error
   ibq_addr_decode u_decode
   (
      .paddr               (paddr),
      .address_switch_bank (address_switch_bank),
      .hit                 (hit),
      .sel                 (sel)
   );

   // switches 5 and 6 are deliberately left unread
   assign base            = vector_switch_bank[`IBQ_SW_BASE_HI:`IBQ_SW_BASE_LO];
   assign sole_controller = ~vector_switch_bank[`IBQ_SW_SOLE];

   // sole controller: never answers a parallel poll set up by anyone else
   assign ppoll_drive = 1'b0;

   assign setup     = psel & ~penable;
   assign access_wr = psel & penable & pwrite & ~err_q;
   assign access_rd = psel & penable & ~pwrite & ~err_q;

   // zero wait states: read data is caught in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & err_q;

   assign talk_ready = talker_active & tx_ready;

   // event sources; service request and talker-ready are edge-detected so a clear sticks, the others set status while high
   assign events[`IBQ_C_ERR1] = error_source_one & sole_controller;
   assign events[`IBQ_C_ERR2] = error_source_two;
   assign events[`IBQ_C_SRQ]  = service_request & ~srq_q;
   assign events[`IBQ_C_CMD]  = command_event;
   assign events[`IBQ_C_TKR]  = talk_ready & ~talk_ready_q;
   assign events[`IBQ_C_LNR]  = rx_valid & listener_active;

   assign pend = status & enable;
   assign irq  = |pend;

   ibq_prio u_prio
   (
      .pend   (pend),
      .base   (base),
      .any    (any_pend),
      .slot   (slot),
      .served (served),
      .vector (next_vector)
   );

   // set wins over both the software clear and the acknowledge clear
   always @*
   begin
      next_status = status;
      if (access_wr && sel_q == `IBQ_SEL_CLEAR)
      begin
         next_status = next_status & ~pwdata[`IBQ_CAUSE_W-1:0];
      end
      if (iack && any_pend)
      begin
         next_status = next_status & ~served;
      end
      next_status = next_status | events;
   end

   always @*
   begin
      next_prdata = {`IBQ_DW{1'b0}};
      case (sel)
         `IBQ_SEL_CSR:
         begin
            next_prdata[`IBQ_CSR_HOLD_TX]  = hold_tx;
            next_prdata[`IBQ_CSR_TALKER]   = talker_active;
            next_prdata[`IBQ_CSR_LISTENER] = listener_active;
            next_prdata[`IBQ_CSR_RX_FULL]  = rx_full;
            next_prdata[`IBQ_CSR_SOLE]     = sole_controller;
            next_prdata[`IBQ_CSR_IRQ]      = irq;
         end
         `IBQ_SEL_DATA:
         begin
            next_prdata[7:0] = rx_hold;
         end
         `IBQ_SEL_STATUS:
         begin
            next_prdata[`IBQ_CAUSE_W-1:0] = status;
         end
         `IBQ_SEL_ENABLE:
         begin
            next_prdata[`IBQ_CAUSE_W-1:0] = enable;
         end
         `IBQ_SEL_VECTOR:
         begin
            next_prdata[`IBQ_VEC_W-1:0] = last_vector;
         end
         default:
         begin
            next_prdata = {`IBQ_DW{1'b0}};
         end
      endcase
   end

   // bus side: decode and read data latched in setup
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         err_q  <= 1'b0;
         sel_q  <= `IBQ_SEL_CSR;
         prdata <= {`IBQ_DW{1'b0}};
      end
      else if (setup)
      begin
         err_q  <= ~hit;
         sel_q  <= sel;
         prdata <= hit ? next_prdata : {`IBQ_DW{1'b0}};
      end
   end

   // control registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_tx <= 1'b0;
         enable  <= {`IBQ_CAUSE_W{1'b0}};
      end
      else if (access_wr)
      begin
         if (sel_q == `IBQ_SEL_CSR)
         begin
            hold_tx <= pwdata[`IBQ_CSR_HOLD_TX];
         end
         if (sel_q == `IBQ_SEL_ENABLE)
         begin
            enable <= pwdata[`IBQ_CAUSE_W-1:0];
         end
      end
   end

   // outgoing byte: only the low byte is used, and only while talker
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_valid <= 1'b0;
         tx_byte  <= 8'h00;
      end
      else
      begin
         tx_valid <= 1'b0;
         if (access_wr && sel_q == `IBQ_SEL_DATA && talker_active)
         begin
            tx_byte  <= pwdata[7:0];
            tx_valid <= ~hold_tx;
         end
      end
   end

   // incoming byte: a new byte overwrites an unread one, newest wins
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_full <= 1'b0;
         rx_hold <= 8'h00;
      end
      else if (rx_valid && listener_active)
      begin
         rx_full <= 1'b1;
         rx_hold <= rx_byte;
      end
      else if (access_rd && sel_q == `IBQ_SEL_DATA)
      begin
         rx_full <= 1'b0;
      end
   end

   // sticky causes and edge history
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status       <= {`IBQ_CAUSE_W{1'b0}};
         talk_ready_q <= 1'b0;
         srq_q        <= 1'b0;
      end
      else
      begin
         status       <= next_status;
         talk_ready_q <= talk_ready;
         srq_q        <= service_request;
      end
   end

   // acknowledge: present the winner for one cycle, keep it readable
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vector_valid <= 1'b0;
         vector_out   <= {`IBQ_VEC_W{1'b0}};
         last_vector  <= {`IBQ_VEC_W{1'b0}};
      end
      else
      begin
         vector_valid <= iack & any_pend;
         if (iack && any_pend)
         begin
            vector_out  <= next_vector;
            last_vector <= next_vector;
         end
      end
   end

endmodule
`default_nettype wire

// file: tb/ibq_irq_sva.sv
`default_nettype none
module ibq_irq_sva
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pslverr,
   input wire logic       talker_active,
   input wire logic       tx_valid,
   input wire logic       ppoll_drive,
   input wire logic       iack,
   input wire logic       irq,
   input wire logic [7:0] vector_switch_bank,
   input wire logic       vector_valid,
   input wire logic [8:0] vector_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_vec_base: assert property (vector_valid |-> vector_out[8:4] == $past(vector_switch_bank[4:0]))
      else $error("vector base bits wrong");
   a_vec_ack: assert property (iack && irq |=> vector_valid)
      else $error("acknowledge got no vector");
   a_vec_cause: assert property (vector_valid |-> $past(iack) && $past(irq))
      else $error("vector without acknowledge");
   a_vec_hold: assert property (!vector_valid |-> $stable(vector_out))
      else $error("vector changed between acknowledges");
   a_tx_talker: assert property (tx_valid |-> $past(talker_active) || $past(talker_active, 2))
      else $error("byte sent while not talker");
   a_tx_pulse: assert property (tx_valid |=> !tx_valid)
      else $error("byte strobe too long");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   a_ppoll_quiet: assert property (!ppoll_drive)
      else $error("parallel poll answered");
endmodule

bind ibq_irq_vectoring ibq_irq_sva u_ibq_irq_sva (.pclk, .presetn, .psel, .penable, .pslverr, .talker_active,
   .tx_valid, .ppoll_drive, .iack, .irq, .vector_switch_bank, .vector_valid, .vector_out);
`default_nettype wire

// file: tb/ibq_host_model.sv
`default_nettype none
module ibq_host_model
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic go,
   output var  logic iack
);
   timeunit 1ns;
   timeprecision 1ps;
   // acknowledge is a one-cycle strobe; go is obeyed even with irq low, so ignored acks get exercised
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         iack <= 1'h0;
      else
         iack <= go && !iack;
   end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [16:0] CSR = 17'h1c0d0, DAT = 17'h1c0d4, STA = 17'h1c0d8, ENA = 17'h1c0dc, CLR = 17'h1c0e0;
   localparam logic [16:0] BAD = 17'h1c0e8, VEC = 17'h1c0e4;
   int          err_count = 0;
   int          n_checks = 0;
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, go = 1'h0;
   logic        error_source_one = 1'h0, error_source_two = 1'h0, service_request = 1'h0, command_event = 1'h0;
   logic        talker_active = 1'h0, listener_active = 1'h0, tx_ready = 1'h0, rx_valid = 1'h0;
   logic        pready, pslverr, tx_valid, ppoll_drive, vector_valid, irq, iack, e, seen;
   logic [16:0] paddr = 17'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic [11:0] address_switch_bank = 12'h034;
   logic [7:0]  vector_switch_bank = 8'h91;
   logic [7:0]  rx_byte = 8'h0;
   logic [7:0]  tx_byte;
   logic [8:0]  vector_out;

   ibq_irq_vectoring u_ibq_irq_vectoring (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .address_switch_bank, .vector_switch_bank, .error_source_one, .error_source_two,
      .service_request, .command_event, .talker_active, .listener_active, .tx_ready, .rx_valid, .rx_byte,
      .tx_valid, .tx_byte, .ppoll_drive, .iack, .vector_valid, .vector_out, .irq);
   ibq_host_model u_ibq_host_model (.pclk, .presetn, .go, .iack);

   always #5 pclk = ~pclk;

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp)
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count += int'(got !== exp);
   endtask

   task automatic apb(input logic w, input logic [16:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic ev(input logic a, input logic c);
      @(posedge pclk);
      error_source_one <= a;
      command_event <= c;
      @(posedge pclk);
      error_source_one <= 1'h0;
      command_event <= 1'h0;
   endtask

   task automatic ack(input logic [8:0] v, input logic want);
      seen = 1'h0;
      @(posedge pclk);
      go <= 1'h1;
      @(posedge pclk);
      go <= 1'h0;
      repeat (4)
      begin
         @(posedge pclk);
         #1;
         if (vector_valid === 1'h1)
            chk(vector_out, v);
         seen |= (vector_valid === 1'h1);
      end
      chk(seen, want);
   endtask

   task automatic t_prio;
      apb(1'h1, ENA, 32'h3f);
      @(posedge pclk);
      {error_source_two, service_request, command_event, rx_valid} <= 4'hf;
      {talker_active, tx_ready, listener_active} <= 3'h7;
      rx_byte <= 8'h5a;
      @(posedge pclk);
      {error_source_two, command_event, rx_valid} <= 3'h0;
      apb(1'h0, STA, 32'h0);
      chk(q, 32'h3e);
      for (int k = 0; k < 4; k++)
         ack(9'h110 + 9'(k * 4), 1'h1);
      chk(irq, 1'h0);
   endtask

   task automatic t_err1;
      ev(1'h1, 1'h0);
      apb(1'h0, STA, 32'h0);
      chk(q, 32'h0);
      // switches 5 and 6 closed as well: they must leave the vector alone
      vector_switch_bank <= 8'h61;
      ev(1'h1, 1'h0);
      apb(1'h0, CSR, 32'h0);
      chk(q[4], 1'h1);
      ack(9'h010, 1'h1);
      apb(1'h0, VEC, 32'h0);
      chk(q, 32'h010);
   endtask

   task automatic t_mask;
      apb(1'h1, ENA, 32'h0);
      ev(1'h0, 1'h1);
      apb(1'h0, STA, 32'h0);
      chk(q, 32'h8);
      chk(irq, 1'h0);
      ack(9'h0, 1'h0);
      apb(1'h1, ENA, 32'h8);
      apb(1'h0, ENA, 32'h0);
      chk(q, 32'h8);
      chk(irq, 1'h1);
      apb(1'h1, CLR, 32'h8);
      apb(1'h0, CLR, 32'h0);
      chk({q, irq}, 33'h0);
      apb(1'h0, BAD, 32'h0);
      chk(e, 1'h1);
   endtask

   task automatic t_data;
      apb(1'h0, DAT, 32'h0);
      chk({e, q}, 33'h5a);
      apb(1'h1, DAT, 32'h1a5);
      seen = 1'h0;
      repeat (3)
      begin
         #1;
         seen |= (tx_valid === 1'h1);
         @(posedge pclk);
      end
      chk({seen, tx_byte}, 9'h1a5);
      apb(1'h1, CSR, 32'h1);
      apb(1'h0, CSR, 32'h0);
      chk(q, 32'h17);
      apb(1'h1, DAT, 32'h33);
      seen = 1'h0;
      repeat (3)
      begin
         #1;
         seen |= (tx_valid === 1'h1);
         @(posedge pclk);
      end
      chk({seen, tx_byte}, 9'h033);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      repeat (10)
         @(posedge pclk);
      presetn <= 1'h1;
      t_prio;
      t_err1;
      t_mask;
      t_data;
      tally_and_finish;
   end

   initial
   begin
      #50us;
      err_count++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish;
   end
endmodule
`default_nettype wire
